// >>> bench/lfem_ctrl_model.sv
// lfem_ctrl_model: behavioural machine controller on the enable/fault-reset pin
// assumes: bench drives requests at the falling edge; model answers at falling edges
`timescale 1ns/1ns
module lfem_ctrl_model (
  input  wire logic clk_sys_in,
  input  wire logic supply_ok_in,
  input  wire logic run_req_in,
  input  wire logic reset_req_in,
  output logic      enable_out
);
  // ------------------------------------------------------------
  // enable and fault-reset sequencing
  // ------------------------------------------------------------
  logic [1:0] open_cnt_ff;

  initial begin
    enable_out  = 1'b0;
    open_cnt_ff = 2'h0;
  end

  // open for four falling edges, well above the two-sample glitch filter
  always @(negedge clk_sys_in) begin
    if (reset_req_in) begin
      open_cnt_ff <= 2'h3;
      enable_out  <= 1'b0;
    end else if (open_cnt_ff != 2'h0) begin
      open_cnt_ff <= open_cnt_ff - 2'h1;
      enable_out  <= 1'b0;
    end else begin
      enable_out  <= run_req_in && supply_ok_in; // close only once supply is up
    end
  end
endmodule

// >>> bench/lfem_top_bench.sv
// lfem_top_bench: self-checking bench for lfem_top
// assumes: 20 MHz clock, asynchronous active-low reset, controller model on enable
`timescale 1ns/1ns
module lfem_top_bench;
  logic clk_sys_in = 1'b0;
  logic rst_n_in   = 1'b0;
  logic supply_ok_in = 1'b0;
  logic terminal_cond_in = 1'b0;
  logic run_req = 1'b0;
  logic reset_req = 1'b0;
  logic [3:0] cond = 4'h0; // temp, shutter, refl, duty
  logic enable;
  logic laser_on, power_reduce, system_fault, refl_warn, duty_warn;
  logic temp_fault, shutter_fault, power_led;
  logic [3:0] flags;
  int err_count = 0;
  int checked = 0;

  always #25 clk_sys_in = ~clk_sys_in;

  lfem_ctrl_model ctrl (.clk_sys_in(clk_sys_in), .supply_ok_in(supply_ok_in),
    .run_req_in(run_req), .reset_req_in(reset_req), .enable_out(enable));

  lfem_top dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .supply_ok_in(supply_ok_in),
    .enable_in(enable), .terminal_cond_in(terminal_cond_in), .temp_cond_in(cond[0]),
    .shutter_cond_in(cond[1]), .refl_cond_in(cond[2]), .duty_cond_in(cond[3]),
    .laser_on_out(laser_on), .power_reduce_out(power_reduce),
    .system_fault_out(system_fault), .reflected_power_warning_out(refl_warn),
    .duty_limit_warning_out(duty_warn), .temp_fault_out(temp_fault),
    .shutter_fault_out(shutter_fault), .power_led_out(power_led));

  assign flags = {duty_warn, refl_warn, shutter_fault, temp_fault};

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  task automatic chk(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic pulse_reset();
    reset_req <= 1'b1;
    step(1);
    reset_req <= 1'b0;
    step(8);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    step(2);
    chk(laser_on, 1'b0);
    chk(system_fault, 1'b0);
    step(3);
    rst_n_in <= 1'b1;
    run_req  <= 1'b1;
    step(3);
    chk(power_led, 1'b0);
    chk(laser_on, 1'b0);
    supply_ok_in <= 1'b1;
    step(6);
    chk(power_led, 1'b1);
    chk(laser_on, 1'b1);
    // disruptive limits: corrected, laser stays on
    for (int i = 2; i < 4; i++) begin
      cond[i] <= 1'b1;
      step(2);
      chk(flags[i], 1'b1);
      chk(laser_on, 1'b1);
      chk(power_reduce, 1'b1);
      chk(system_fault, 1'b0);
      cond[i] <= 1'b0;
      step(2);
      chk(flags[i], 1'b0);
      chk(power_reduce, 1'b0);
    end
    // latching faults: immediate shutdown, hold after clear, release on toggle
    for (int i = 0; i < 2; i++) begin
      cond[i] <= 1'b1;
      step(1);
      chk(laser_on, 1'b0);
      chk(flags[i], 1'b1);
      chk(flags[1-i], 1'b0);
      chk(system_fault, 1'b1);
      pulse_reset();
      chk(flags[i], 1'b1);
      cond[i] <= 1'b0;
      step(8);
      chk(laser_on, 1'b0);
      chk(system_fault, 1'b1);
      pulse_reset();
      chk(flags[i], 1'b0);
      chk(system_fault, 1'b0);
      chk(laser_on, 1'b1);
    end
    // supply loss: laser and green indicator go dark, enable follows
    supply_ok_in <= 1'b0;
    step(2);
    chk(laser_on, 1'b0);
    chk(power_led, 1'b0);
    supply_ok_in <= 1'b1;
    step(4);
    chk(power_led, 1'b1);
    chk(laser_on, 1'b1);
    run_req <= 1'b0;
    step(4);
    chk(laser_on, 1'b0);
    // terminal condition found at power-up
    rst_n_in <= 1'b0;
    terminal_cond_in <= 1'b1;
    run_req <= 1'b1;
    step(3);
    rst_n_in <= 1'b1;
    step(8);
    chk(system_fault, 1'b1);
    chk(laser_on, 1'b0);
    chk(temp_fault, 1'b0);
    chk(shutter_fault, 1'b0);
    terminal_cond_in <= 1'b0;
    pulse_reset();
    chk(laser_on, 1'b0);
    close_out();
  end

  // tests need well under 300 cycles; cut a hang at 2000
  initial begin
    #(50 * 2000);
    err_count++;
    close_out();
  end
endmodule

// >>> design/lfem_toggle_det.sv
// lfem_toggle_det: detects an open-then-close sequence on the enable input
// assumes: enable input synchronous to clk_sys_in, high means closed to return
`timescale 1ns/1ns
module lfem_toggle_det (
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  input  wire logic enable_in,
  output logic      toggle_out
);
  import lfem_pkg::*;

  // ------------------------------------------------------------
  // open-phase tracking
  // ------------------------------------------------------------
  logic [1:0] open_cnt_ff;
  logic       enable_d_ff;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      open_cnt_ff <= 2'h0;
    end else if (!enable_in) begin
      if (open_cnt_ff != OPEN_CNT_MAX) begin
        open_cnt_ff <= open_cnt_ff + 2'h1;
      end
    end else begin
      open_cnt_ff <= 2'h0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      enable_d_ff <= 1'b0;
    end else begin
      enable_d_ff <= enable_in;
    end
  end

  // a reclose after a long enough open; short glitches are ignored
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      toggle_out <= 1'b0;
    end else begin
      toggle_out <= enable_in && !enable_d_ff && (open_cnt_ff == OPEN_CNT_MAX); // [R8]
    end
  end

endmodule

// >>> design/lfem_top.sv
// lfem_top: enable, fault classification and fault-reset control
// assumes: all inputs synchronous to clk_sys_in; power-up drives rst_n_in
//
// Contract
// (R1) After a latching fault the laser stays off even when the cause clears until a reset toggle.
// (R2) The controller enables only after supply is up and the laser never runs without enable.
// (R3) A latched fault raises the summary fault output within microseconds of laser shutdown.
// (R4) Reflected-power and duty-cycle limits are corrected without shutdown and flagged apart.
// (R5) Terminal conditions are checked at power-up and, if found, block all laser operation.
// (R6) A terminal fault shows only on the summary fault output, with no dedicated pin.
// (R7) Temperature or shutter faults shut down at once, latch, and each has its own output.
// (R8) A latch is released only by an enable toggle once its condition has cleared.
// (R9) The green power indicator is lit whenever the supply is present.
// (R10) The controller closes enable to its return and opens then recloses it to reset.
// (R11) The summary fault output is high while any system fault is present; the code raises it only once the state is latched or terminal.
`timescale 1ns/1ns
module lfem_top (
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  input  wire logic supply_ok_in,
  input  wire logic enable_in,
  input  wire logic terminal_cond_in,
  input  wire logic temp_cond_in,
  input  wire logic shutter_cond_in,
  input  wire logic refl_cond_in,
  input  wire logic duty_cond_in,
  output logic      laser_on_out,
  output logic      power_reduce_out,
  output logic      system_fault_out,
  output logic      reflected_power_warning_out,
  output logic      duty_limit_warning_out,
  output logic      temp_fault_out,
  output logic      shutter_fault_out,
  output logic      power_led_out
);
  import lfem_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  lfem_state_t state_ff;
  lfem_state_t nxt_state;
  logic        toggle;
  logic        temp_lat_ff;
  logic        shut_lat_ff;
  logic        latch_clear;
  logic        cond_any;

  assign cond_any    = temp_cond_in || shutter_cond_in;
  // release only once the cause is gone
  assign latch_clear = toggle && !cond_any; // [R8]

  lfem_toggle_det u_toggle (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .enable_in  (enable_in),
    .toggle_out (toggle)
  );

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      LFEM_ST_POWER_WAIT: begin
        if (supply_ok_in) begin
          nxt_state = LFEM_ST_CHECK;
        end
      end
      LFEM_ST_CHECK: begin
        // one-shot check at power-up only
        if (terminal_cond_in) begin
          nxt_state = LFEM_ST_TERMINAL; // [R5]
        end else begin
          nxt_state = LFEM_ST_IDLE;
        end
      end
      LFEM_ST_IDLE: begin
        // a cause caught before idle is still a latched fault
        if (cond_any || temp_lat_ff || shut_lat_ff) begin
          nxt_state = LFEM_ST_LATCHED; // [R7]
        end else if (enable_in && supply_ok_in) begin
          nxt_state = LFEM_ST_RUN; // [R2]
        end
      end
      LFEM_ST_RUN: begin
        if (cond_any) begin
          nxt_state = LFEM_ST_LATCHED; // [R7]
        end else if (!enable_in || !supply_ok_in) begin
          nxt_state = LFEM_ST_IDLE; // [R2]
        end
      end
      LFEM_ST_LATCHED: begin
        // no self-restart when the cause clears
        if (latch_clear) begin
          nxt_state = LFEM_ST_IDLE; // [R1] [R8]
        end
      end
      LFEM_ST_TERMINAL: begin
        nxt_state = LFEM_ST_TERMINAL; // [R5]
      end
      default: begin
        nxt_state = LFEM_ST_POWER_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= LFEM_ST_POWER_WAIT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ------------------------------------------------------------
  // latches of temperature and shutter causes
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      temp_lat_ff <= 1'b0;
      shut_lat_ff <= 1'b0;
    end else begin
      // a new cause wins over a release in the same cycle
      temp_lat_ff <= temp_cond_in || (temp_lat_ff && !latch_clear); // [R7] [R8]
      shut_lat_ff <= shutter_cond_in || (shut_lat_ff && !latch_clear); // [R7] [R8]
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // laser on only in run and not already faulting this cycle
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      laser_on_out <= RST_OUT_VAL;
    end else begin
      laser_on_out <= (nxt_state == LFEM_ST_RUN) && enable_in && !cond_any; // [R2] [R7]
    end
  end

  // disruptive limits: reduce drive, keep running
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      power_reduce_out            <= RST_OUT_VAL;
      reflected_power_warning_out <= RST_OUT_VAL;
      duty_limit_warning_out      <= RST_OUT_VAL;
    end else begin
      power_reduce_out            <= refl_cond_in || duty_cond_in; // [R4]
      reflected_power_warning_out <= refl_cond_in; // [R4]
      duty_limit_warning_out      <= duty_cond_in; // [R4]
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      temp_fault_out    <= RST_OUT_VAL;
      shutter_fault_out <= RST_OUT_VAL;
    end else begin
      temp_fault_out    <= temp_cond_in || (temp_lat_ff && !latch_clear); // [R7]
      shutter_fault_out <= shutter_cond_in || (shut_lat_ff && !latch_clear); // [R7]
    end
  end

  // same edge as the shutdown, well inside the microsecond budget
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      system_fault_out <= RST_OUT_VAL;
    end else begin
      system_fault_out <= (nxt_state == LFEM_ST_LATCHED)
                       || (nxt_state == LFEM_ST_TERMINAL); // [R3] [R6] [R11]
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      power_led_out <= RST_OUT_VAL;
    end else begin
      power_led_out <= supply_ok_in; // [R9]
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  localparam int FLAG_MAX = int'(FAULT_FLAG_CYC);

  AST_NO_RUN_WITHOUT_EN: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !enable_in |=> !laser_on_out) // [R2]
    else $error("laser on without enable");
  AST_FAULT_FLAG_FAST: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $fell(laser_on_out) && state_ff == LFEM_ST_LATCHED
      |-> ##[0:FLAG_MAX] system_fault_out) // [R3]
    else $error("summary fault late after shutdown");
  AST_TEMP_SHUTDOWN: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    temp_cond_in |=> !laser_on_out && temp_fault_out) // [R7]
    else $error("temperature fault did not shut down");
  AST_SHUT_SHUTDOWN: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    shutter_cond_in |=> !laser_on_out && shutter_fault_out) // [R7]
    else $error("shutter fault did not shut down");
  AST_NO_SELF_RESTART: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    state_ff == LFEM_ST_LATCHED && !toggle |=> state_ff == LFEM_ST_LATCHED) // [R1] [R8]
    else $error("latch left without toggle");
  AST_DISRUPT_NO_STOP: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    laser_on_out && enable_in && supply_ok_in && !cond_any && refl_cond_in
      |=> laser_on_out && reflected_power_warning_out) // [R4]
    else $error("reflected power limit stopped laser");
  AST_DUTY_FLAG: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    duty_cond_in |=> duty_limit_warning_out && power_reduce_out) // [R4]
    else $error("duty limit not flagged");
  AST_TERMINAL_BLOCK: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    state_ff == LFEM_ST_CHECK && terminal_cond_in
      |=> ##1 (system_fault_out && !laser_on_out)[*8]) // [R5] [R6]
    else $error("terminal fault did not block laser");
  AST_LED: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    $rose(supply_ok_in) |=> power_led_out) // [R9]
    else $error("power led not lit");
  AST_FAULT_LEVEL: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    state_ff == LFEM_ST_LATCHED |-> system_fault_out) // [R11]
    else $error("summary fault low while latched");

  COV_RUN: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) $rose(laser_on_out));
  COV_LATCH_RELEASE: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    state_ff == LFEM_ST_LATCHED ##1 state_ff == LFEM_ST_IDLE);
  COV_TERMINAL: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    state_ff == LFEM_ST_TERMINAL);
  COV_DISRUPT: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    laser_on_out && reflected_power_warning_out);

endmodule

// >>> inc/lfem_pkg.sv
// lfem_pkg: constants and types for the laser fault and enable manager
// assumes: single 20 MHz clock domain, no register bus
package lfem_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20_000_000;
  // longest time from shutdown to summary fault, in ns
  localparam int unsigned FAULT_FLAG_NS   = 2_000;
  localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  localparam int unsigned FAULT_FLAG_CYC  =
    ((FAULT_FLAG_NS / CLK_PERIOD_NS) < 1) ? 1 : (FAULT_FLAG_NS / CLK_PERIOD_NS);
  // cycles of enable-open needed to count as a reset toggle
  localparam int unsigned EN_OPEN_MIN_CYC = 2;
  localparam logic [1:0]  OPEN_CNT_MAX    = 2'(EN_OPEN_MIN_CYC);

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic RST_OUT_VAL = 1'b0;

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    LFEM_ST_POWER_WAIT,
    LFEM_ST_CHECK,
    LFEM_ST_IDLE,
    LFEM_ST_RUN,
    LFEM_ST_LATCHED,
    LFEM_ST_TERMINAL
  } lfem_state_t;

endpackage
